// ---- hw/slc_buf2.sv ----
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module slc_buf2 #(
	parameter int W = 8
) (
	input  wire logic mclk,  // Controller clock
	input  wire logic rst_n, // Asynchronous reset, active low
	slc_buf_if.snk    fill,  // Filling side
	slc_buf_if.src    drain  // Draining side
);
	import slc_pkg::*;

	typedef struct packed {
		logic [W-1:0] e0;
		logic [W-1:0] e1;
		logic [1:0]   cnt;
		logic         rdy;
		logic         vld;
	} slc_buf_type;

	// Empty buffer: ready to fill, nothing to drain
	localparam slc_buf_type BUF_IDLE = '{e0: '0, e1: '0, cnt: 2'h0, rdy: 1'b1, vld: 1'b0};

	slc_buf_type st_q;
	slc_buf_type st_d;
	logic        push;
	logic        pop;

	assign fill.ready  = st_q.rdy;
	assign drain.valid = st_q.vld;
	assign drain.data  = st_q.e0;
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.valid && drain.ready;

	always_comb
	begin
		st_d = st_q;
		if (pop)
		begin
			st_d.e0 = st_q.e1;
		end
		if (push)
		begin
			if (st_q.cnt == 2'h0 || (st_q.cnt == 2'h1 && pop))
				st_d.e0 = fill.data;
			else
				st_d.e1 = fill.data;
		end
		st_d.cnt = st_q.cnt + 2'(push) - 2'(pop);
		st_d.rdy = (st_d.cnt != 2'h2);
		st_d.vld = (st_d.cnt != 2'h0);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= BUF_IDLE;
		else
			st_q <= st_d;
	end

	a_buf_no_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_q.cnt == 2'h2 && !pop) |=> st_q.cnt == 2'h2)
		else $error("buffer lost or gained a word while full");
endmodule // slc_buf2
`default_nettype wire

// ---- hw/slc_buf_if.sv ----
// Valid/ready byte channel between the command unit and its buffer
`default_nettype none
interface slc_buf_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hw/slc_cmd_unit.sv ----
// Level one command unit of a parallel bus protocol controller
// Operation
// - Extended-feature reset loads microcode revision into first command byte register.
// - Parity/attention checked at 4096-byte boundaries; extended receive aborts immediately.
// - REQ/ACK corruption aborts send or receive, interrupt status 25 hex.
// - SEL glitch dropping device off bus reports 85 or 41 hex.
// - Reset in every state: stop command, disconnect, status 00 or 01.
// - Abort honoured only when disconnected or connected as target.
// - Abort before arbitration won returns idle with paused/aborted interrupt.
// - Abort after arbitration drops IDs keeps SEL; BSY within 200 us decides.
// - Abort of select-and-transfer: 85 hex if target gone, else ignored.
// - Outbound abort withdraws data request, drains FIFO to bus first.
// - Inbound abort completes only after FIFO emptied to host.
// - Target abort keeps remaining count, stays target, accepts target commands.
// - Disconnect in initiator, target, SCAM releases bus; stops commands except in SCAM.
// - Assert ATN only as initiator; released automatically on listed events.
// - Negate ACK releases held ACK; ACK held at listed interrupts.
// - Other initiator transfers negate ACK automatically; host parity irrelevant. Here ACK clears only on Negate ACK, Disconnect, reset or bus free.
// - Command 0F enables mid-operation disconnect interrupt.
// - Set Phase in SCAM drives MSG, C/D, I/O from image bits 2..0.
// - Set Data in SCAM drives data image with correct parity.
// - Read Bus samples lines; initiator data is last inbound REQ value.
// - 2C filters short selections, rescales timeout; 2D enables SCAM selection.
// - Commands in invalid states are ignored without interrupt.
// - Commands other than reset and abort complete without interrupt.
`default_nettype none
module slc_cmd_unit #(
	parameter int SEL_FILTER_CYC = slc_pkg::SCAM_FILT_CYC
) (
	input  wire logic                     mclk,           // Controller clock, 10 MHz
	input  wire logic                     rst_n,          // Asynchronous reset, active low
	input  wire logic                     cmd_wr,         // Command register write strobe
	input  wire logic [7:0]               cmd_code,       // Command code written
	input  wire logic                     adv_en,         // Advanced features bit of identity config
	input  wire logic                     radv_en,        // Extended features bit of identity config
	input  wire logic                     irq_ack,        // Host clears interrupt
	input  wire logic                     role_set,       // Level II engine reports new connection
	input  wire logic [1:0]               role_code,      // Connection entered
	input  wire logic                     sel_active,     // Selection or reselection attempt running
	input  wire logic                     sel_resel,      // Attempt is a reselection
	input  wire logic                     arb_won,        // Arbitration won
	input  wire logic                     bus_bsy,        // BSY seen on bus
	input  wire logic                     satx_active,    // Select-and-transfer running
	input  wire logic                     tgt_gone,       // Target has disconnected
	input  wire logic                     send_active,    // Send command running
	input  wire logic                     recv_active,    // Receive command running
	input  wire logic                     tx_fifo_empty,  // Outbound FIFO flushed to bus
	input  wire logic                     rx_fifo_empty,  // Inbound engine FIFO empty
	input  wire logic [15:0]              xfer_left,      // Bytes not yet moved on bus
	input  wire logic                     par_fault,      // Synchronous parity fault seen
	input  wire logic                     atn_seen,       // Attention condition seen
	input  wire logic                     blk_boundary,   // 4096-byte boundary reached
	input  wire logic                     proto_err,      // REQ/ACK corruption detected
	input  wire logic                     sel_glitch,     // SEL glitch dropped device off bus
	input  wire logic                     sel_atn_req,    // Select-with-ATN asks for ATN
	input  wire logic                     atn_release,    // Last message-out byte or identify sent
	input  wire logic                     bus_free,       // Bus free phase seen
	input  wire logic                     ack_hold_evt,   // Transfer ended with ACK to be held
	input  wire logic [7:0]               bus_ctl_in,     // Bus control lines
	input  wire logic [7:0]               bus_data_in,    // Bus data lines
	input  wire logic [7:0]               req_data,       // Data latched at last inbound REQ
	input  wire logic                     sel_seen,       // Valid selection phase on bus
	input  wire logic                     rx_valid,       // Inbound byte valid
	input  wire logic [7:0]               rx_data,        // Inbound byte
	output logic                          rx_ready,       // Buffer accepts inbound byte
	output logic                          host_valid,     // Byte ready for host
	output logic [7:0]                    host_data,      // Byte to host
	input  wire logic                     host_ready,     // Host takes byte
	output logic                          irq_out,        // Interrupt level
	output logic [7:0]                    bus_event_code_reg, // Interrupt status code
	output logic [7:0]                    first_cmd_byte_reg, // First command byte register
	output logic [7:0]                    phase_line_image_reg, // Control line image
	output logic [7:0]                    data_line_image_reg,  // Data line image
	output slc_pkg::slc_conn_type         conn_out,       // Connection state
	output logic                          atn_out,        // Drive ATN
	output logic                          ack_hold_out,   // Keep ACK asserted
	output logic                          mid_disconnect_irq_enable, // Mid-operation disconnect interrupt
	output logic [slc_pkg::PHASE_W-1:0]   phase_drv,      // MSG, C/D, I/O drive values
	output logic                          phase_oe,       // Phase lines driven
	output logic [7:0]                    data_drv,       // Data line drive values
	output logic                          data_par,       // Data parity drive value
	output logic                          data_oe,        // Data lines driven
	output logic                          id_drop,        // Remove IDs, keep SEL
	output logic                          l2_stop,        // Terminate Level II command
	output logic                          l2_halt,        // Boundary halt request
	output logic                          dma_request_pin_mask, // Withdraw data request
	output logic [15:0]                   remain_cnt,     // Remaining byte count
	output logic                          scam_tolerant,  // Tolerant timing and timeout scaling
	output logic                          scam_sel_en,    // SCAM selection response enabled
	output logic                          sel_accept      // Selection may be answered
);
	import slc_pkg::*;

	typedef struct packed {
		slc_conn_type         conn;
		slc_abort_type        ab;
		logic                 adv;
		logic                 radv;
		logic                 atn;
		logic                 ack;
		logic                 disc_ie;
		logic                 tol;
		logic                 ssel;
		logic [PHASE_W-1:0]   ph;
		logic                 ph_oe;
		logic [7:0]           dat;
		logic                 par;
		logic                 dat_oe;
		logic [7:0]           ctl_img;
		logic [7:0]           dat_img;
		logic [7:0]           first_byte;
		logic                 irq;
		logic [7:0]           status;
		logic [TMR_W-1:0]     tmr;
		logic [15:0]          remain;
		logic                 id_drop;
		logic                 stop;
		logic                 halt;
		logic                 mask;
		logic                 pend;
		logic [FILT_W-1:0]    filt;
		logic                 acc;
	} slc_state_type;

	slc_state_type st_q;
	slc_state_type st_d;
	slc_buf_if     in_if ();
	slc_buf_if     out_if ();

	assign in_if.valid  = rx_valid;
	assign in_if.data   = rx_data;
	assign rx_ready     = in_if.ready;
	assign host_valid   = out_if.valid;
	assign host_data    = out_if.data;
	assign out_if.ready = host_ready;

	slc_buf2 #(.W(8)) u_buf (
		.mclk  (mclk),
		.rst_n (rst_n),
		.fill  (in_if),
		.drain (out_if)
	);

	always_comb
	begin
		logic       ev;
		logic [7:0] code;
		logic       fault;
		ev    = 1'b0;
		code  = ST_SUCCESS;
		st_d  = st_q;
		st_d.stop = 1'b0;
		st_d.halt = 1'b0;
		fault = par_fault || atn_seen;
		if (!sel_seen)
			st_d.filt = '0;
		else if (st_q.filt <= FILT_W'(SEL_FILTER_CYC))
			st_d.filt = st_q.filt + 1'b1;
		st_d.acc = sel_seen && (!st_q.tol || st_q.filt > FILT_W'(SEL_FILTER_CYC));
		if (sel_atn_req)
			st_d.atn = 1'b1;
		if (atn_release || bus_free)
			st_d.atn = 1'b0;
		// hold ACK, only the listed events hold it
		if (ack_hold_evt)
			st_d.ack = 1'b1;
		else if (bus_free)
			st_d.ack = 1'b0;
		if (role_set)
			st_d.conn = slc_conn_type'(role_code);
		if (fault && recv_active && st_q.radv && st_q.ab == AB_IDLE)
		begin
			st_d.ab   = AB_RXDR;
			st_d.mask = 1'b0;
		end
		else if (fault)
			st_d.pend = 1'b1;
		if (st_q.pend && blk_boundary)
		begin
			st_d.halt = 1'b1;
			st_d.pend = 1'b0;
		end
		// wait for BSY after dropping IDs
		if (st_q.ab == AB_SELW)
		begin
			if (bus_bsy)
			begin
				ev = 1'b1;
				code = ST_SUCCESS;
				st_d.ab = AB_IDLE;
				st_d.id_drop = 1'b0;
				st_d.conn = sel_resel ? CN_TGT : CN_INIT;
			end
			else if (st_q.tmr == TMR_W'(1))
			begin
				ev = 1'b1;
				code = ST_ABORTED;
				st_d.ab = AB_IDLE;
				st_d.id_drop = 1'b0;
				st_d.stop = 1'b1;
			end
			else
				st_d.tmr = st_q.tmr - 1'b1;
		end
		// drain, then report and keep count
		if ((st_q.ab == AB_TXDR && tx_fifo_empty) ||
			(st_q.ab == AB_RXDR && rx_fifo_empty && !out_if.valid))
		begin
			ev = 1'b1;
			code = ST_ABORTED;
			st_d.ab = AB_IDLE;
			st_d.mask = 1'b0;
			st_d.stop = 1'b1;
			st_d.remain = xfer_left;
			st_d.conn = CN_TGT;
		end
		if (sel_glitch)
		begin
			ev = 1'b1;
			code = satx_active ? ST_BUSFREE_L2 : ST_BUSFREE;
			st_d.conn = CN_DISC;
			st_d.stop = 1'b1;
		end
		if (proto_err && (send_active || recv_active))
		begin
			ev = 1'b1;
			code = ST_PROTO_ERR;
			st_d.stop = 1'b1;
			st_d.remain = xfer_left;
			st_d.ab = AB_IDLE;
			st_d.mask = 1'b0;
		end
		// decode with state check; silent unless reset or abort
		if (cmd_wr)
		begin
			unique case (cmd_code)
				CMD_RESET:
				begin
					st_d = '0;
					st_d.conn = CN_DISC;
					st_d.adv = adv_en;
					st_d.radv = radv_en;
					st_d.stop = 1'b1;
					st_d.ctl_img = st_q.ctl_img;
					st_d.dat_img = st_q.dat_img;
					st_d.first_byte = st_q.first_byte;
					if (radv_en)
						st_d.first_byte = UCODE_REV;
					ev = 1'b1;
					code = adv_en ? ST_RESET_ADV : ST_RESET;
				end
				CMD_ABORT:
				begin
					if (st_q.conn == CN_DISC && st_q.ab == AB_IDLE)
					begin
						if (satx_active)
						begin
							if (tgt_gone)
							begin
								ev = 1'b1;
								code = ST_BUSFREE_L2;
								st_d.stop = 1'b1;
							end
						end
						else if (sel_active && !arb_won)
						begin
							ev = 1'b1;
							code = ST_ABORTED;
							st_d.stop = 1'b1;
						end
						else if (sel_active)
						begin
							st_d.ab = AB_SELW;
							st_d.id_drop = 1'b1;
							st_d.tmr = TMR_W'(SEL_ABORT_CYC);
						end
					end
					else if (st_q.conn == CN_TGT && st_q.ab == AB_IDLE)
					begin
						if (send_active)
						begin
							st_d.ab = AB_TXDR;
							st_d.mask = 1'b1;
						end
						else if (recv_active)
							st_d.ab = AB_RXDR;
					end
				end
				CMD_ATN:
				begin
					if (st_q.conn == CN_INIT)
						st_d.atn = 1'b1;
				end
				CMD_NEG_ACK:
				begin
					if (st_q.conn == CN_INIT)
						st_d.ack = 1'b0;
				end
				CMD_DISC:
				begin
					if (st_q.conn != CN_DISC)
					begin
						st_d.stop = (st_q.conn != CN_SCAM);
						st_d.conn = CN_DISC;
						st_d.atn = 1'b0;
						st_d.ack = 1'b0;
						st_d.ph_oe = 1'b0;
						st_d.dat_oe = 1'b0;
						st_d.id_drop = 1'b0;
						st_d.ab = AB_IDLE;
						st_d.mask = 1'b0;
					end
				end
				CMD_DISC_IE:
				begin
					if (st_q.conn != CN_SCAM)
						st_d.disc_ie = 1'b1;
				end
				CMD_SET_PHASE:
				begin
					if (st_q.conn == CN_SCAM)
					begin
						st_d.ph = st_q.ctl_img[PHASE_W-1:0];
						st_d.ph_oe = 1'b1;
					end
				end
				CMD_SET_DATA:
				begin
					if (st_q.conn == CN_SCAM)
					begin
						st_d.dat = st_q.dat_img;
						st_d.par = ~^st_q.dat_img;
						st_d.dat_oe = 1'b1;
					end
				end
				CMD_READ_BUS:
				begin
					st_d.ctl_img = bus_ctl_in;
					st_d.dat_img = (st_q.conn == CN_INIT) ? req_data : bus_data_in;
				end
				CMD_SCAM_TOL:
				begin
					if (st_q.conn == CN_DISC)
						st_d.tol = 1'b1;
				end
				CMD_SCAM_SEL:
				begin
					if (st_q.conn == CN_DISC)
						st_d.ssel = 1'b1;
				end
				default:
				begin
				end
			endcase
		end
		// Event wins over a same-cycle clear
		if (ev)
		begin
			st_d.irq = 1'b1;
			st_d.status = code;
		end
		else if (irq_ack)
			st_d.irq = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign irq_out                   = st_q.irq;
	assign bus_event_code_reg        = st_q.status;
	assign first_cmd_byte_reg        = st_q.first_byte;
	assign phase_line_image_reg      = st_q.ctl_img;
	assign data_line_image_reg       = st_q.dat_img;
	assign conn_out                  = st_q.conn;
	assign atn_out                   = st_q.atn;
	assign ack_hold_out              = st_q.ack;
	assign mid_disconnect_irq_enable = st_q.disc_ie;
	assign phase_drv                 = st_q.ph;
	assign phase_oe                  = st_q.ph_oe;
	assign data_drv                  = st_q.dat;
	assign data_par                  = st_q.par;
	assign data_oe                   = st_q.dat_oe;
	assign id_drop                   = st_q.id_drop;
	assign l2_stop                   = st_q.stop;
	assign l2_halt                   = st_q.halt;
	assign dma_request_pin_mask      = st_q.mask;
	assign remain_cnt                = st_q.remain;
	assign scam_tolerant             = st_q.tol;
	assign scam_sel_en               = st_q.ssel;
	assign sel_accept                = st_q.acc;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_cmd(logic [7:0] c);
		cmd_wr && cmd_code == c;
	endsequence

	a_reset_status_code: assert property (s_cmd(CMD_RESET) |=> irq_out && bus_event_code_reg ==
		($past(adv_en) ? ST_RESET_ADV : ST_RESET) && conn_out == CN_DISC)
		else $error("reset did not report its status");
	a_reset_rev_load: assert property ((s_cmd(CMD_RESET) && radv_en) |=> first_cmd_byte_reg == UCODE_REV)
		else $error("revision not loaded on reset");
	a_proto_abort: assert property ((proto_err && recv_active && !(cmd_wr && cmd_code == CMD_RESET))
		|=> irq_out && bus_event_code_reg == ST_PROTO_ERR && l2_stop)
		else $error("protocol error not reported");
	// Timer stays in range and counts down every waiting cycle, so the wait is bounded
	a_selw_bound: assert property ((st_q.ab == AB_SELW) |->
		(id_drop && st_q.tmr != '0 && st_q.tmr <= TMR_W'(SEL_ABORT_CYC))
		##1 (st_q.ab == AB_IDLE || st_q.tmr < $past(st_q.tmr)))
		else $error("selection abort wait not bounded");
	a_disc_release: assert property ((s_cmd(CMD_DISC) && conn_out == CN_INIT)
		|=> conn_out == CN_DISC && !atn_out && !phase_oe && !data_oe && l2_stop)
		else $error("disconnect did not release bus");
	a_atn_initiator: assert property ((s_cmd(CMD_ATN) && conn_out != CN_INIT && !atn_out && !sel_atn_req)
		|=> !atn_out)
		else $error("ATN asserted outside initiator state");
	a_set_phase_drive: assert property ((s_cmd(CMD_SET_PHASE) && conn_out == CN_SCAM)
		|=> phase_oe && phase_drv == $past(phase_line_image_reg[PHASE_W-1:0]))
		else $error("phase lines not driven from image");
	a_set_data_par: assert property ((s_cmd(CMD_SET_DATA) && conn_out == CN_SCAM)
		|=> data_oe && data_drv == $past(data_line_image_reg) && (^{data_drv, data_par}))
		else $error("data or parity wrong on set data");
	a_disc_ie_silent: assert property ((s_cmd(CMD_DISC_IE) && conn_out == CN_INIT && !irq_out && !sel_glitch
		&& !proto_err && st_q.ab == AB_IDLE) |=> mid_disconnect_irq_enable && !irq_out)
		else $error("disconnect interrupt enable misbehaved");
	a_rx_abort_drain: assert property ((st_q.ab == AB_RXDR && host_valid) |=> !(irq_out && !$past(irq_out)
		&& bus_event_code_reg == ST_ABORTED))
		else $error("receive abort finished with bytes waiting");
endmodule // slc_cmd_unit
`default_nettype wire

// ---- hw/slc_pkg.sv ----
// Constants and types shared by the level one command unit
`default_nettype none
package slc_pkg;
	localparam int          CLK_NS        = 100;
	localparam int          SEL_ABORT_NS  = 200000;
	localparam int          SEL_ABORT_CYC = (SEL_ABORT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          SCAM_FILT_NS  = 4000000;
	localparam int          SCAM_FILT_CYC = (SCAM_FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TMR_W         = 16;
	localparam int          FILT_W        = 24;
	localparam logic [7:0]  CMD_RESET     = 8'h00;
	localparam logic [7:0]  CMD_ABORT     = 8'h01;
	localparam logic [7:0]  CMD_ATN       = 8'h02;
	localparam logic [7:0]  CMD_NEG_ACK   = 8'h03;
	localparam logic [7:0]  CMD_DISC      = 8'h04;
	localparam logic [7:0]  CMD_DISC_IE   = 8'h0F;
	localparam logic [7:0]  CMD_SET_PHASE = 8'h28;
	localparam logic [7:0]  CMD_SET_DATA  = 8'h29;
	localparam logic [7:0]  CMD_READ_BUS  = 8'h2A;
	localparam logic [7:0]  CMD_SCAM_TOL  = 8'h2C;
	localparam logic [7:0]  CMD_SCAM_SEL  = 8'h2D;
	localparam logic [7:0]  ST_RESET      = 8'h00;
	localparam logic [7:0]  ST_RESET_ADV  = 8'h01;
	localparam logic [7:0]  ST_PROTO_ERR  = 8'h25;
	localparam logic [7:0]  ST_BUSFREE_L2 = 8'h85;
	localparam logic [7:0]  ST_BUSFREE    = 8'h41;
	localparam logic [7:0]  ST_SUCCESS    = 8'h16;
	localparam logic [7:0]  ST_ABORTED    = 8'h21;
	localparam logic [7:0]  UCODE_REV     = 8'h5A;
	localparam int          PHASE_W       = 3;

	typedef enum logic [1:0] {
		CN_DISC = 2'b00,
		CN_TGT  = 2'b01,
		CN_INIT = 2'b10,
		CN_SCAM = 2'b11
	} slc_conn_type;

	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_SELW = 2'b01,
		AB_TXDR = 2'b10,
		AB_RXDR = 2'b11
	} slc_abort_type;
endpackage
`default_nettype wire

// ---- tb/slc_cmd_unit_tb.sv ----
// Self-checking bench for the level one command unit
`default_nettype none
module slc_cmd_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import slc_pkg::*;
	logic mclk, rst_n, cmd_wr, adv_en, radv_en, irq_ack, role_set, sel_active, sel_resel, arb_won, bus_bsy;
	logic satx_active, tgt_gone, send_active, recv_active, tx_fifo_empty, rx_fifo_empty, par_fault, atn_seen;
	logic blk_boundary, proto_err, sel_glitch, sel_atn_req, atn_release, bus_free, ack_hold_evt, sel_seen;
	logic rx_valid, rx_ready, host_valid, host_ready, irq_out, atn_out, ack_hold_out, mid_disconnect_irq_enable;
	logic phase_oe, data_par, data_oe, id_drop, l2_stop, l2_halt, dma_request_pin_mask, scam_tolerant;
	logic scam_sel_en, sel_accept, go;
	logic [1:0]   role_code;
	logic [2:0]   phase_drv;
	logic [3:0]   n_bytes;
	logic [7:0]   cmd_code, bus_ctl_in, bus_data_in, req_data, rx_data, host_data, bus_event_code_reg;
	logic [7:0]   first_cmd_byte_reg, phase_line_image_reg, data_line_image_reg, data_drv;
	logic [15:0]  xfer_left, remain_cnt;
	slc_conn_type conn_out;
	int           error_cnt, checks, i;
	logic [7:0]   got[$];
	slc_cmd_unit #(.SEL_FILTER_CYC(20)) u_dut (.*);
	slc_link_model u_link (.mclk(mclk), .rst_n(rst_n), .go(go), .n_bytes(n_bytes),
		.rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	always #50 mclk = ~mclk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic pls(ref logic s);
		s = 1'b1;
		#100;
		s = 1'b0;
	endtask
	task automatic cmd(input logic [7:0] c);
		#100;
		cmd_code = c;
		pls(cmd_wr);
	endtask
	task automatic role(input logic [1:0] c);
		role_code = c;
		pls(role_set);
	endtask
	task automatic wirq;
		for (i = 0; i < 3000 && irq_out !== 1'b1; i++)
			#100;
		chk(irq_out, 1);
		if (irq_out !== 1'b1)
			print_verdict;
	endtask
	task automatic stat(input logic [7:0] c);
		wirq;
		chk(bus_event_code_reg, c);
		pls(irq_ack);
	endtask
	initial
	begin
		{mclk, rst_n, cmd_wr, adv_en, radv_en, irq_ack, role_set, sel_active, sel_resel, arb_won, bus_bsy,
			satx_active, tgt_gone, send_active, recv_active, tx_fifo_empty, rx_fifo_empty, par_fault,
			atn_seen, blk_boundary, proto_err, sel_glitch, sel_atn_req, atn_release, bus_free, ack_hold_evt,
			sel_seen, host_ready, go, role_code, n_bytes, cmd_code, bus_ctl_in, bus_data_in, req_data,
			xfer_left} = '0;
		repeat (12) @(posedge mclk);
		#1 rst_n = 1'b1;
		{adv_en, radv_en} = 2'b11;
		cmd(CMD_RESET);
		chk({l2_stop, conn_out}, 3'h4);
		stat(ST_RESET_ADV);
		chk(first_cmd_byte_reg, UCODE_REV);
		{adv_en, radv_en} = 2'b00;
		cmd(CMD_RESET);
		stat(ST_RESET);
		$display("test reset done");
		role(2'b10);
		pls(ack_hold_evt);
		cmd(CMD_ATN);
		chk({atn_out, ack_hold_out}, 2'h3);
		cmd(CMD_NEG_ACK);
		chk(ack_hold_out, 0);
		cmd(CMD_DISC_IE);
		chk({irq_out, mid_disconnect_irq_enable}, 2'h1);
		cmd(CMD_ABORT);
		pls(atn_release);
		chk({irq_out, atn_out}, 0);
		cmd(CMD_DISC);
		chk({l2_stop, conn_out}, 3'h4);
		cmd(CMD_ATN);
		chk({irq_out, atn_out}, 0);
		$display("test initiator done");
		role(2'b11);
		{bus_ctl_in, bus_data_in} = 16'hFAA5;
		cmd(CMD_READ_BUS);
		chk({phase_line_image_reg, data_line_image_reg}, 16'hFAA5);
		cmd(CMD_SET_PHASE);
		chk({phase_oe, phase_drv}, 4'hA);
		cmd(CMD_SET_DATA);
		chk({irq_out, data_oe, data_par, data_drv}, 11'h3A5);
		cmd(CMD_DISC);
		chk({phase_oe, data_oe, conn_out}, 0);
		$display("test scam done");
		cmd(CMD_SCAM_SEL);
		cmd(CMD_SCAM_TOL);
		chk({scam_sel_en, scam_tolerant}, 2'h3);
		sel_seen = 1'b1;
		#1800;
		chk(sel_accept, 0);
		#500;
		chk(sel_accept, 1);
		sel_seen = 1'b0;
		sel_active = 1'b1;
		cmd(CMD_ABORT);
		stat(ST_ABORTED);
		arb_won = 1'b1;
		cmd(CMD_ABORT);
		chk(id_drop, 1);
		wirq;
		chk(i >= 2000, 1);
		stat(ST_ABORTED);
		cmd(CMD_ABORT);
		#1000;
		bus_bsy = 1'b1;
		stat(ST_SUCCESS);
		chk({id_drop, conn_out}, 3'h2);
		{sel_active, arb_won, bus_bsy} = 3'h0;
		cmd(CMD_DISC);
		{satx_active, tgt_gone} = 2'h3;
		cmd(CMD_ABORT);
		stat(ST_BUSFREE_L2);
		{satx_active, tgt_gone} = 2'h0;
		$display("test abort done");
		role(2'b01);
		send_active = 1'b1;
		pls(par_fault);
		pls(blk_boundary);
		chk(l2_halt, 1);
		pls(proto_err);
		stat(ST_PROTO_ERR);
		send_active = 1'b0;
		pls(sel_glitch);
		stat(ST_BUSFREE);
		chk(conn_out, CN_DISC);
		role(2'b01);
		send_active = 1'b1;
		cmd(CMD_ABORT);
		chk({dma_request_pin_mask, irq_out}, 2'h2);
		tx_fifo_empty = 1'b1;
		stat(ST_ABORTED);
		chk(dma_request_pin_mask, 0);
		{send_active, tx_fifo_empty} = 2'h0;
		{recv_active, xfer_left, n_bytes} = {1'b1, 16'h0123, 4'h3};
		pls(go);
		#400;
		chk(rx_ready, 0);
		cmd(CMD_ABORT);
		#300;
		chk(irq_out, 0);
		{rx_fifo_empty, host_ready} = 2'h3;
		for (i = 0; i < 40 && irq_out !== 1'b1; i++)
		begin
			if (host_valid === 1'b1)
				got.push_back(host_data);
			#100;
		end
		chk(got.size(), 3);
		foreach (got[k])
			chk(got[k], 8'hB3 - k);
		chk(remain_cnt, 16'h0123);
		chk(conn_out, CN_TGT);
		stat(ST_ABORTED);
		$display("test target done");
		print_verdict;
	end
endmodule // slc_cmd_unit_tb
`default_nettype wire

// ---- tb/slc_link_model.sv ----
// Far-side byte source for the inbound channel of the command unit
`default_nettype none
module slc_link_model (
	input  wire logic       mclk,     // Controller clock
	input  wire logic       rst_n,    // Reset, active low
	input  wire logic       go,       // Start a burst
	input  wire logic [3:0] n_bytes,  // Burst length
	input  wire logic       rx_ready, // Unit takes byte
	output logic            rx_valid, // Byte offered
	output logic [7:0]      rx_data   // Byte value
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left_q;
	assign rx_valid = left_q != 4'h0;
	// Released lines show the inverse of the last byte
	assign rx_data = rx_valid ? {4'hB, left_q} : 8'h4E;
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			left_q <= 4'h0;
		else if (go)
			left_q <= n_bytes;
		else if (rx_valid && rx_ready)
			left_q <= left_q - 4'h1;
endmodule // slc_link_model
`default_nettype wire
